// file: rtl/spc_pkg.sv
// shared port pin control package: register map, field layouts, option encodings
// assumes a 32-bit axi4-lite register bus and one 100 MHz core clock
package spc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_DIR = 4'h0;
    localparam logic [3:0] ADDR_WAKE = 4'h4;
    localparam logic [3:0] ADDR_PULL = 4'h8;
    localparam logic [3:0] ADDR_DATA = 4'hc;
    localparam logic [3:0] ADDR_PIN = 4'hc;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_CFG = 4'h8;

    // ----------------------------------------------------------------
    // reset values and response codes
    // ----------------------------------------------------------------
    localparam logic [6:0] DIR_RESET = 7'h7f;
    localparam logic [7:0] WAKE_RESET = 8'h00;
    localparam logic [6:0] PULL_RESET = 7'h00;
    localparam logic [6:0] DATA_RESET = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // status and configuration field positions
    // ----------------------------------------------------------------
    localparam int STAT_WAKE_BIT = 0;
    localparam int CFG_BUZ_BIT = 0;
    localparam int CFG_OSC_LSB = 1;
    localparam int CFG_RESET_BIT = 3;
    localparam int CFG_FREQ_LSB = 4;

    // ----------------------------------------------------------------
    // oscillator mode and internal rc frequency variant
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_INT_RC = 2'h0,
        OSC_CRYSTAL = 2'h1,
        OSC_RC_RTC = 2'h2,
        OSC_EXT_RC = 2'h3
    } spc_osc_type;

    typedef enum logic [1:0] {
        FREQ_4MHZ = 2'h0,
        FREQ_8MHZ = 2'h1,
        FREQ_12MHZ = 2'h2
    } spc_freq_type;

    // fixed options sampled once after reset release
    typedef struct packed {
        logic buzzer_on;
        spc_osc_type osc_mode;
        logic reset_pin_on;
        spc_freq_type rc_freq;
    } spc_opt_type;

    // pin triple for the seven two-way lines
    typedef struct packed {
        logic [6:0] out;
        logic [6:0] oe;
        logic [6:0] pull;
    } spc_pad_type;

endpackage : spc_pkg

// file: rtl/spc_port.sv
// shared port pin control: direction, wake-up, pull-high and pin sharing for an 8-line port
// assumes synchronous pin inputs and fixed option straps, axi4-lite master that keeps the protocol
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// What this block does
// - each port line has its own wake-up enable bit; a change then raises wake-up unless the line is held by the buzzer, oscillator or reset option
// - each two-way line not held by the buzzer or oscillator option is software-selectable as driven output or sampled input
// - lines zero to six each have a software pull-high enable
// - a fixed option gives lines zero and one to the complementary buzzer pair
// - line two also feeds the timer external input
// - line three also feeds the external interrupt input
// - a fixed option picks one of four oscillator modes; internal rc frees lines five and six, external rc frees line five only
// - internal rc frequency is a fixed variant value: 4, 8 or 12 MHz
// - a fixed option makes line seven the active-low reset input or a plain input
// - line seven supports wake-up while it is a plain input, and has no pull-high
module spc_port import spc_pkg::*; #(
    parameter int NUM_IO = 7
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    // fixed configuration options
    input wire logic OPT_BUZZER_IN,
    input wire logic [1:0] OPT_OSC_MODE_IN,
    input wire logic OPT_RESET_PIN_IN,
    input wire logic [1:0] OPT_RC_FREQ_IN,
    // pins
    input wire logic [7:0] PAD_IN,
    output logic [6:0] PAD_OUT,
    output logic [6:0] PAD_OE_OUT,
    output logic [6:0] PAD_PULL_OUT,
    // shared functions
    input wire logic BUZZER_SIGNAL_IN,
    output logic TIMER_EXTERNAL_INPUT_OUT,
    output logic EXT_INT_OUT,
    output logic OSC_INPUT_PIN_OUT,
    input wire logic OSC_OUTPUT_PIN_IN,
    output logic OSC_OUTPUT_PIN_OE_OUT,
    output logic RESET_INPUT_PIN_N_OUT,
    output logic [1:0] RC_FREQ_OUT,
    output logic WAKE_OUT,
    // axi4-lite slave
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    if (NUM_IO != 7) begin : gen_bad_num_io
        $error("spc_port serves exactly seven two-way lines");
    end

    // ----------------------------------------------------------------
    // option capture after reset release
    // ----------------------------------------------------------------
    spc_opt_type opt;
    logic opt_done;
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            opt <= '0;
            opt_done <= 1'b0;
        end else if (!opt_done) begin
            opt <= {OPT_BUZZER_IN, spc_osc_type'(OPT_OSC_MODE_IN), OPT_RESET_PIN_IN,
                    spc_freq_type'(OPT_RC_FREQ_IN == 2'h3 ? 2'h0 : OPT_RC_FREQ_IN)};
            opt_done <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    logic [6:0] dir_in; // 1 = input
    logic [7:0] wake_en;
    logic [6:0] pull_en;
    logic [6:0] out_data;
    logic wake_flag;
    logic [7:0] pin_prev;
    logic [7:0] wake_mask;

    logic aw_hold, w_hold;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire do_write = aw_hold && w_hold && !S_AXI_BVALID;
    wire wr_hit = (aw_addr == ADDR_DIR) || (aw_addr == ADDR_WAKE) || (aw_addr == ADDR_PULL)
                  || (aw_addr == ADDR_DATA);
    wire clr_wake = do_write && aw_addr == ADDR_WAKE && w_strb[1] && w_data[8];

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dir_in <= DIR_RESET;
            wake_en <= WAKE_RESET;
            pull_en <= PULL_RESET;
            out_data <= DATA_RESET;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                ADDR_DIR: dir_in <= w_data[6:0];
                ADDR_WAKE: wake_en <= w_data[7:0];
                ADDR_PULL: pull_en <= w_data[6:0];
                ADDR_DATA: out_data <= w_data[6:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin ownership and pad drive
    // ----------------------------------------------------------------
    logic [6:0] osc_owned;
    always_comb begin
        osc_owned = 7'h00;
        case (opt.osc_mode)
            OSC_INT_RC: osc_owned = 7'h00;
            OSC_CRYSTAL, OSC_RC_RTC: osc_owned = 7'h60;
            OSC_EXT_RC: osc_owned = 7'h40;
            default: osc_owned = 7'h00;
        endcase
    end

    logic [6:0] next_oe, next_out;
    always_comb begin
        next_oe = ~dir_in & ~osc_owned;
        next_out = out_data;
        if (opt.buzzer_on) begin
            next_oe[1:0] = 2'h3;
            next_out[0] = BUZZER_SIGNAL_IN;
            next_out[1] = ~BUZZER_SIGNAL_IN;
        end
        if (osc_owned[5]) begin
            next_oe[5] = 1'b0;
            next_out[5] = OSC_OUTPUT_PIN_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PAD_OE_OUT <= 7'h00;
            PAD_OUT <= 7'h00;
            PAD_PULL_OUT <= 7'h00;
            OSC_OUTPUT_PIN_OE_OUT <= 1'b0;
        end else begin
            PAD_OE_OUT <= next_oe;
            PAD_OUT <= next_out;
            // buzzer lines are driven, so their pull-high stays off
            PAD_PULL_OUT <= pull_en & ~next_oe & ~osc_owned;
            OSC_OUTPUT_PIN_OE_OUT <= osc_owned[5];
        end
    end

    // ----------------------------------------------------------------
    // shared inputs, wake detection
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            TIMER_EXTERNAL_INPUT_OUT <= 1'b0;
            EXT_INT_OUT <= 1'b0;
            OSC_INPUT_PIN_OUT <= 1'b0;
            RESET_INPUT_PIN_N_OUT <= 1'b1;
            RC_FREQ_OUT <= 2'h0;
            pin_prev <= 8'h00;
            wake_flag <= 1'b0;
            WAKE_OUT <= 1'b0;
        end else begin
            TIMER_EXTERNAL_INPUT_OUT <= PAD_IN[2];
            EXT_INT_OUT <= PAD_IN[3];
            OSC_INPUT_PIN_OUT <= osc_owned[6] & PAD_IN[6];
            RESET_INPUT_PIN_N_OUT <= opt.reset_pin_on ? PAD_IN[7] : 1'b1;
            RC_FREQ_OUT <= opt.rc_freq;
            pin_prev <= PAD_IN;
            if (|((PAD_IN ^ pin_prev) & wake_en & wake_mask)) begin
                wake_flag <= 1'b1;
            end else if (clr_wake) begin
                wake_flag <= 1'b0;
            end
            WAKE_OUT <= wake_flag;
        end
    end

    always_comb begin
        wake_mask = {~opt.reset_pin_on, ~osc_owned};
        if (opt.buzzer_on) begin
            wake_mask[1:0] = 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= RESP_OKAY;
            case (S_AXI_ARADDR)
                ADDR_DIR: S_AXI_RDATA <= {25'h0, dir_in};
                ADDR_WAKE: S_AXI_RDATA <= {23'h0, wake_flag, wake_en};
                ADDR_PULL: S_AXI_RDATA <= {25'h0, pull_en};
                ADDR_DATA: S_AXI_RDATA <= {24'h0, PAD_IN};
                default: begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_reset_inputs;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) !opt_done |-> PAD_OE_OUT == 7'h00 && PAD_PULL_OUT == 7'h00;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("lines driven before configuration");
    property p_dir;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) !opt.buzzer_on && osc_owned == 7'h00
            |=> PAD_OE_OUT[4:2] == ~$past(dir_in[4:2]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not followed");
    property p_pull;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) PAD_OE_OUT != 7'h00 |-> (PAD_PULL_OUT & PAD_OE_OUT) == 7'h00;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-high on driven line");
    property p_buzz;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) opt.buzzer_on && opt_done
            |=> PAD_OE_OUT[1:0] == 2'h3 && PAD_OUT[0] != PAD_OUT[1];
    endproperty
    a_buzz: assert property (p_buzz) else $error("buzzer pair not complementary");
    property p_timer;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) opt_done |=> TIMER_EXTERNAL_INPUT_OUT == $past(PAD_IN[2]);
    endproperty
    a_timer: assert property (p_timer) else $error("timer input not from line two");
    property p_int;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) opt_done |=> EXT_INT_OUT == $past(PAD_IN[3]);
    endproperty
    a_int: assert property (p_int) else $error("interrupt input not from line three");
    property p_osc;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) opt.osc_mode == OSC_CRYSTAL
            |=> !PAD_OE_OUT[6] && !PAD_OE_OUT[5];
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator pins driven as port");
    property p_wake;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) wake_en[7] && !opt.reset_pin_on && $changed(PAD_IN[7])
            |=> ##1 WAKE_OUT;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up missed");
    property p_rst;
        @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) !opt.reset_pin_on |=> RESET_INPUT_PIN_N_OUT;
    endproperty
    a_rst: assert property (p_rst) else $error("reset asserted while line seven is a port");
    c_write: cover property (@(posedge CORE_CLK_IN) S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (@(posedge CORE_CLK_IN) S_AXI_RVALID && S_AXI_RREADY);
    c_wake: cover property (@(posedge CORE_CLK_IN) WAKE_OUT);

endmodule : spc_port

// file: verification/spc_pad_model.sv
// outside circuitry on the port pins: resolves each line from device, outside drivers and pull-high
// assumes the bench never drives a line that the device drives
`timescale 1ns/1ps
module spc_pad_model import spc_pkg::*; (
    // device side
    input wire logic clk_in,
    input wire logic [6:0] pad_out_in,
    input wire logic [6:0] pad_oe_in,
    input wire logic [6:0] pad_pull_in,
    // outside drivers
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] level_out
);
    logic [7:0] float_pat = 8'h5a;
    // a released line keeps changing so a stale level is never mistaken for a driven one
    always @(posedge clk_in) float_pat <= ~float_pat;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i < 7 && pad_oe_in[i % 7]) level_out[i] = pad_out_in[i % 7];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (i < 7 && pad_pull_in[i % 7]) level_out[i] = 1'b1;
            else level_out[i] = float_pat[i];
        end
    end
endmodule : spc_pad_model

// file: verification/test_spc_port.sv
// self-checking bench for the shared port pin control block
// assumes the pad model stands on the pins and the bench acts as axi4-lite master
`timescale 1ns/1ps
module test_spc_port import spc_pkg::*;;
    logic clk = 0, rst_n = 0, buz = 0, rstp = 0, bz = 0, oso = 0;
    logic [1:0] osc = 0, frq = 0, bresp, rresp;
    logic [7:0] lvl, ext_en = 0, ext_val = 0;
    logic [6:0] p_out, p_oe, p_pull;
    logic tmr, eint, osi, osoe, rpin, wake, awr, wr, bv, arr, rv;
    logic [1:0] rcf;
    logic [3:0] awa = 0, ara = 0, wst = 0;
    logic [31:0] wd = 0, rd, rnd = 32'h3fe1, got;
    logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
    logic [1:0] resp;
    int miscompares = 0, checks = 0;
    always #5 clk = ~clk;
    spc_port spc_port_i (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .OPT_BUZZER_IN(buz), .OPT_OSC_MODE_IN(osc),
        .OPT_RESET_PIN_IN(rstp), .OPT_RC_FREQ_IN(frq), .PAD_IN(lvl), .PAD_OUT(p_out), .PAD_OE_OUT(p_oe),
        .PAD_PULL_OUT(p_pull), .BUZZER_SIGNAL_IN(bz), .TIMER_EXTERNAL_INPUT_OUT(tmr), .EXT_INT_OUT(eint),
        .OSC_INPUT_PIN_OUT(osi), .OSC_OUTPUT_PIN_IN(oso), .OSC_OUTPUT_PIN_OE_OUT(osoe),
        .RESET_INPUT_PIN_N_OUT(rpin), .RC_FREQ_OUT(rcf), .WAKE_OUT(wake), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rrd));
    spc_pad_model spc_pad_model_i (.clk_in(clk), .pad_out_in(p_out), .pad_oe_in(p_oe), .pad_pull_in(p_pull),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic step();
        rnd = lfsr(rnd);
    endtask : step
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        awa <= a; wd <= d; wst <= s; awv <= 1; wv <= 1; brd <= 1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
        end while (!bv);
        resp = bresp;
        brd <= 0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        ara <= a; arv <= 1; rrd <= 1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
        end while (!rv);
        d = rd;
        resp = rresp;
        rrd <= 0;
        @(posedge clk);
    endtask : rd_reg
    task automatic do_reset(input logic b, input logic [1:0] m, input logic r, input logic [1:0] f);
        rst_n <= 0; buz <= b; osc <= m; rstp <= r; frq <= f;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
    endtask : do_reset
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic o5, o6;
        logic [6:0] dir, pul, dat, ex;
        for (int i = 0; i < 4; i++) begin
            step();
            do_reset(i[0], i[1:0], i[1], rnd[1:0]);
            o6 = (i != 0);
            o5 = (i == 1 || i == 2);
            bz <= rnd[4]; oso <= rnd[5]; ext_en <= {1'b1, o6, 6'h00}; ext_val <= 8'h40;
            wr_reg(ADDR_DIR, 32'h0, 4'hf);
            wr_reg(ADDR_DATA, {25'h0, rnd[14:8]}, 4'hf);
            repeat (2) @(posedge clk);
            ex = rnd[14:8];
            if (i[0]) ex[1:0] = {~bz, bz};
            cmp("out", {27'h0, ex[4:0]}, {27'h0, p_out[4:0]});
            cmp("oe", {25'h0, ~o6, ~o5, 5'h1f}, {25'h0, p_oe});
            cmp("osc oe", {31'h0, o5}, {31'h0, osoe});
            if (o5) cmp("osc out", {31'h0, oso}, {31'h0, p_out[5]});
            cmp("osc in", {31'h0, o6}, {31'h0, osi});
            cmp("freq", {30'h0, (rnd[1:0] == 2'h3) ? 2'h0 : rnd[1:0]}, {30'h0, rcf});
            cmp("reset pin", {31'h0, ~i[1]}, {31'h0, rpin});
            $display("test option set %0d done", i);
        end
        do_reset(0, OSC_INT_RC, 0, FREQ_12MHZ);
        cmp("oe rst", 32'h0, {25'h0, p_oe});
        cmp("pull rst", 32'h0, {25'h0, p_pull});
        rd_reg(ADDR_DIR, got);
        cmp("dir rst", {25'h0, DIR_RESET}, got);
        rd_reg(ADDR_WAKE, got);
        cmp("wake rst", 32'h0, got);
        rd_reg(ADDR_PULL, got);
        cmp("pull reg rst", 32'h0, got);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            step(); dir = rnd[6:0]; pul = rnd[13:7]; dat = rnd[20:14]; ex = rnd[27:21];
            if (k == 0) dir = 7'h7f;
            ext_en <= {1'b1, dir}; ext_val <= {rnd[28], ex};
            wr_reg(ADDR_DIR, {rnd[31:7], dir}, 4'hf);
            wr_reg(ADDR_PULL, {rnd[31:7], pul}, 4'hf);
            wr_reg(ADDR_DATA, {25'h0, dat}, 4'hf);
            repeat (2) @(posedge clk);
            cmp("oe", {25'h0, ~dir}, {25'h0, p_oe});
            cmp("pull", {25'h0, pul & dir}, {25'h0, p_pull});
            cmp("out", {25'h0, dat & ~dir}, {25'h0, p_out & ~dir});
            cmp("timer in", {31'h0, dir[2] ? ex[2] : dat[2]}, {31'h0, tmr});
            cmp("ext int", {31'h0, dir[3] ? ex[3] : dat[3]}, {31'h0, eint});
            rd_reg(ADDR_PIN, got);
            cmp("pins", {24'h0, rnd[28], (ex & dir) | (dat & ~dir)}, got);
            rd_reg(ADDR_PULL, got);
            cmp("pull reg", {25'h0, pul}, got);
        end
        $display("test direction and pull done");
        wr_reg(ADDR_WAKE, 32'h100, 4'h3);
        ext_val[4] <= ~ext_val[4];
        repeat (4) @(posedge clk);
        cmp("no wake", 32'h0, {31'h0, wake});
        wr_reg(ADDR_WAKE, 32'h90, 4'h1);
        ext_val[7] <= ~ext_val[7];
        repeat (3) @(posedge clk);
        cmp("wake", 32'h1, {31'h0, wake});
        rd_reg(ADDR_STAT, got);
        cmp("wake stat", 32'h190, got);
        wr_reg(ADDR_STAT, 32'h100, 4'h2);
        cmp("wr resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        repeat (2) @(posedge clk);
        rd_reg(ADDR_STAT, got);
        cmp("rd resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        cmp("wake clr", 32'h90, got);
        wr_reg(4'h6, 32'hff, 4'hf);
        cmp("bad wr", {30'h0, RESP_SLVERR}, {30'h0, resp});
        rd_reg(4'h6, got);
        cmp("bad rd", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test wake and bus done");
        print_verdict();
    end
    initial begin
        #(20000 * 10);
        miscompares++;
        print_verdict();
    end
endmodule : test_spc_port
